// ---- hdl/sgp_pin_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_ctrl (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_test_n,
  input wire logic i_float_outputs_n,
  input wire logic i_scan_port_reset_n,
  input wire sgp_pkg::sgp_strap_t i_strap,
  input wire logic i_bus_active,
  input wire logic [15:0] i_pin_func,
  input wire logic [sgp_pkg::NUM_PINS-1:0] i_gpio_out,
  input wire logic [sgp_pkg::NUM_PINS-1:0] i_gpio_oe,
  input wire logic [sgp_pkg::NUM_PINS-1:0] i_pin_in,
  input wire logic i_alarm_one,
  input wire logic i_alarm_two,
  input wire logic i_alarm_five,
  input wire logic i_ref_8khz_out,
  input wire logic i_byte_swap_sel,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_data_strobe_n,
  output logic [sgp_pkg::NUM_PINS-1:0] o_pin_out,
  output logic [sgp_pkg::NUM_PINS-1:0] o_pin_oe,
  output logic [sgp_pkg::NUM_PINS-1:0] o_gpio_in,
  output sgp_pkg::sgp_strap_t o_strap,
  output logic o_ref_8khz_in,
  output logic o_error_insert_in,
  output logic o_perf_monitor_update_in,
  output logic o_scan_test_mode,
  output logic o_float_all,
  output logic o_core_resetn,
  output logic o_rd_req,
  output logic o_wr_req,
  output logic [15:0] o_bus_rdata,
  output logic [1:0] o_bus_lane_oe
);
  import sgp_pkg::*;

  // ***********************************************************
  // reset release
  // ***********************************************************
  logic [1:0] rst_sync_q;
  sgp_state_t state_q;
  sgp_strap_t strap_sync;
  sgp_strap_t strap_q;
  logic [NUM_PINS-1:0] pin_sync;
  sgp_pin_drive_t drive;
  logic [1:0] fn [NUM_PINS];
  logic [1:0] lane_oe_q;

  // assert at once, release on a clock edge so all flops leave together
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign o_core_resetn = rst_sync_q[1];

  // ***********************************************************
  // asynchronous test controls
  // ***********************************************************
  // test inputs are pure levels; no clock so they act with the pins
  assign o_scan_test_mode = ~i_test_n;
  assign o_float_all = ~i_float_outputs_n & ~i_scan_port_reset_n;

  // ***********************************************************
  // strap capture
  // ***********************************************************
  sgp_sync #(
    .WIDTH(3)
  ) u_strap_sync (
    .i_clk(i_clk),
    .i_resetn(o_core_resetn),
    .i_async(i_strap),
    .o_sync(strap_sync)
  );

  sgp_sync #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(o_core_resetn),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
  );

  // straps taken after release, then only between bus cycles
  always_ff @(posedge i_clk or negedge o_core_resetn) begin
    if (!o_core_resetn) begin
      state_q <= ST_RESET;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q <= ST_LATCH;
        end
        ST_LATCH: begin
          if (!i_bus_active) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge o_core_resetn) begin
    if (!o_core_resetn) begin
      strap_q <= STRAP_RST;
    end else if (!i_bus_active && state_q != ST_RESET) begin
      strap_q <= strap_sync;
    end
  end
  assign o_strap = strap_q;

  // ***********************************************************
  // host strobe decode
  // ***********************************************************
  // data-strobe mode takes direction from the write pin level
  always_comb begin
    if (strap_q.data_strobe_mode) begin
      o_rd_req = ~i_data_strobe_n & i_wr_n;
      o_wr_req = ~i_data_strobe_n & ~i_wr_n;
    end else begin
      o_rd_req = ~i_rd_n;
      o_wr_req = ~i_wr_n;
    end
  end

  // byte lanes: narrow bus uses the low lane only
  always_ff @(posedge i_clk or negedge o_core_resetn) begin
    if (!o_core_resetn) begin
      o_bus_rdata <= 16'h0000;
      lane_oe_q <= 2'h0;
    end else begin
      if (i_byte_swap_sel) begin
        o_bus_rdata <= {i_reg_rdata[7:0], i_reg_rdata[15:8]};
      end else begin
        o_bus_rdata <= i_reg_rdata;
      end
      lane_oe_q <= o_rd_req ? {strap_q.wide_bus, 1'b1} : 2'h0;
    end
  end

  // float must act on the level at once, a registered gate would lag an edge
  assign o_bus_lane_oe = o_float_all ? 2'h0 : lane_oe_q;

  // ***********************************************************
  // pin function mux
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      fn[i] = i_pin_func[2*i +: 2];
    end
  end

  // unsupported codes on a pin fall back to plain I/O
  always_comb begin
    drive.out = i_gpio_out;
    drive.oe = i_gpio_oe;
    if (fn[0] == FN_ALARM) begin
      drive.out[0] = i_alarm_one;
      drive.oe[0] = 1'b1;
    end
    if (fn[1] == FN_REF) begin
      drive.out[1] = i_ref_8khz_out;
      drive.oe[1] = 1'b1;
    end else if (fn[1] == FN_ALARM) begin
      drive.out[1] = i_alarm_two;
      drive.oe[1] = 1'b1;
    end
    if (fn[4] == FN_ALARM) begin
      drive.out[4] = i_alarm_five;
      drive.oe[4] = 1'b1;
    end
    // pins four, six and eight become inputs in their dedicated use
    if (fn[3] == FN_REF) begin
      drive.oe[3] = 1'b0;
    end
    if (fn[5] == FN_SPECIAL) begin
      drive.oe[5] = 1'b0;
    end
    if (fn[7] == FN_SPECIAL) begin
      drive.oe[7] = 1'b0;
    end
    // pins three and seven keep plain I/O whatever code is set
  end

  assign o_pin_out = drive.out;
  assign o_pin_oe = o_float_all ? '0 : drive.oe;
  assign o_gpio_in = pin_sync;

  // dedicated inputs read zero unless selected; source timing is the driver's duty
  always_ff @(posedge i_clk or negedge o_core_resetn) begin
    if (!o_core_resetn) begin
      o_ref_8khz_in <= 1'b0;
      o_error_insert_in <= 1'b0;
      o_perf_monitor_update_in <= 1'b0;
    end else begin
      o_ref_8khz_in <= (fn[3] == FN_REF) & pin_sync[3];
      o_error_insert_in <= (fn[5] == FN_SPECIAL) & pin_sync[5];
      o_perf_monitor_update_in <= (fn[7] == FN_SPECIAL) & pin_sync[7];
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  chk_float_all: assert property (@(posedge i_clk)
    (!i_float_outputs_n && !i_scan_port_reset_n) |-> o_pin_oe == '0)
    else $error("pins driven while floated");
  chk_test_mode: assert property (@(posedge i_clk) o_scan_test_mode == !i_test_n)
    else $error("scan mode does not follow test input");
  chk_strap_hold: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    i_bus_active |=> $stable(strap_q))
    else $error("strap changed in bus cycle");
  chk_ds_read: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    (strap_q.data_strobe_mode && !i_data_strobe_n && i_wr_n) |-> o_rd_req && !o_wr_req)
    else $error("data strobe read not decoded");
  chk_rw_write: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    (!strap_q.data_strobe_mode) |-> (o_wr_req == !i_wr_n))
    else $error("write strobe not decoded");
  chk_swap_data: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    o_core_resetn && i_byte_swap_sel |=>
    o_bus_rdata == {$past(i_reg_rdata[7:0]), $past(i_reg_rdata[15:8])})
    else $error("byte swap wrong");
  chk_narrow_lane: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    !strap_q.wide_bus |=> !o_bus_lane_oe[1])
    else $error("upper lane driven on narrow bus");
  chk_alarm_one: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    (fn[0] == FN_ALARM && !o_float_all) |-> o_pin_oe[0] && o_pin_out[0] == i_alarm_one)
    else $error("alarm not on pin one");
  chk_ref_input: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    fn[3] == FN_REF |-> !o_pin_oe[3])
    else $error("reference input pin driven");
  chk_reset_rel: assert property (@(posedge i_clk)
    !i_resetn |=> !o_core_resetn ##1 !o_core_resetn)
    else $error("reset released too early");
  chk_plain_three: assert property (@(posedge i_clk) disable iff (!o_core_resetn)
    !o_float_all |-> o_pin_oe[2] == i_gpio_oe[2] && o_pin_oe[6] == i_gpio_oe[6])
    else $error("pin three or seven not plain");
  chk_lane_float: assert property (@(posedge i_clk)
    o_float_all |-> o_bus_lane_oe == 2'h0)
    else $error("data lanes driven while floated");

  cov_ds_mode: cover property (@(posedge i_clk) strap_q.data_strobe_mode && o_wr_req);
  cov_float: cover property (@(posedge i_clk) o_float_all);
  cov_ref_in: cover property (@(posedge i_clk) o_ref_8khz_in);
  cov_swap: cover property (@(posedge i_clk) i_byte_swap_sel && o_bus_lane_oe == 2'h3);
endmodule
`default_nettype wire

// ---- pkg/sgp_pkg.sv ----
package sgp_pkg;

  // ***********************************************************
  // pin function selections
  // ***********************************************************
  // general-purpose pin function codes, two bits per pin
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALARM = 2'h1;
  localparam logic [1:0] FN_REF = 2'h2;
  localparam logic [1:0] FN_SPECIAL = 2'h3;

  localparam int NUM_PINS = 8;
  localparam logic [NUM_PINS-1:0] PIN_RST = 8'h00;
  localparam logic [2:0] STRAP_RST = 3'h0;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int PULSE_MIN_NS = 500;
  // least time rounds up
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed {
    logic data_strobe_mode;
    logic wide_bus;
    logic serial_mode;
  } sgp_strap_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } sgp_pin_drive_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_LATCH = 3'b010,
    ST_RUN = 3'b100
  } sgp_state_t;

endpackage

// ---- hdl/sgp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; change counts once stages two and three agree
module sgp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import sgp_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // a zero width leaves nothing to synchronise; refuse it at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("sgp_sync width must be positive");
  end

  // stage one is read only by stage two
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // output moves only where the two later stages agree
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sync <= '0;
    end else begin
      // agreeing bits take stage three, disagreeing bits hold, so falls pass too
      o_sync <= (s3_q & ~(s2_q ^ s3_q)) | (o_sync & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

// ---- testbench/sgp_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// board-side pulse sources
// ****
module sgp_board_model #(
  parameter int PHASE_NS = 600,
  parameter int REF_HALF_NS = 62500
) (
  input wire logic i_en,
  output logic o_ref,
  output logic o_err,
  output logic o_pmu
);
  // lines rest low while disabled, so a stale level never reads as a pulse
  initial {o_ref, o_err, o_pmu} = 3'h0;
  // every phase outlasts the 500 ns floor
  always #(PHASE_NS) begin
    o_err = i_en & ~o_err;
    // opposite phase to the error line, so a swap of pins six and eight shows
    o_pmu = i_en & ~o_err;
  end
  // even duty reference at the nominal 8 kHz
  always #(REF_HALF_NS) o_ref = i_en & ~o_ref;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sgp_pkg::*;
  // ****
  // stimulus, observed outputs, tasks
  // ****
  logic i_clk = 1'h0, i_resetn = 1'h0, i_test_n = 1'h1, i_float_outputs_n = 1'h1;
  logic i_scan_port_reset_n = 1'h1, i_bus_active = 1'h0, i_byte_swap_sel = 1'h0;
  logic i_alarm_one = 1'h0, i_alarm_two = 1'h1, i_alarm_five = 1'h0, i_ref_8khz_out = 1'h0;
  logic i_rd_n = 1'h1, i_wr_n = 1'h1, i_data_strobe_n = 1'h1, en = 1'h0;
  sgp_strap_t i_strap = '0, o_strap;
  logic [15:0] i_pin_func = '0, i_reg_rdata = 16'h12c4, o_bus_rdata;
  logic [7:0] i_gpio_out = '0, i_gpio_oe = '0, i_pin_in, o_pin_out, o_pin_oe, o_gpio_in, ex;
  logic o_ref_8khz_in, o_error_insert_in, o_perf_monitor_update_in, o_scan_test_mode;
  logic o_float_all, o_core_resetn, o_rd_req, o_wr_req, m_ref, m_err, m_pmu;
  logic [1:0] o_bus_lane_oe;
  logic [2:0] stm [4] = '{3'h3, 3'h5, 3'h6, 3'h4};
  int n_errors = 0, samples_checked = 0, cyc = 0;

  sgp_pin_ctrl dut (.*);
  sgp_board_model #(.PHASE_NS(600), .REF_HALF_NS(62500)) board (
    .i_en(en),
    .o_ref(m_ref),
    .o_err(m_err),
    .o_pmu(m_pmu)
  );
  // plain pins read back low; pins four, six, eight come from the board
  assign i_pin_in = {m_pmu, 1'h0, m_err, 1'h0, m_ref, 3'h0};
  always #2.5 i_clk = ~i_clk;

  // hang guard; two reference half-periods make the run about 25,000 cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors += 1;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked += 1;
    if (e !== g) begin
      n_errors += 1;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // strobe levels {rd, wr, ds}, then the decoded {read, write} pair
  task automatic strobe(input logic [2:0] rwd, input logic [1:0] e);
    {i_rd_n, i_wr_n, i_data_strobe_n} = rwd;
    #1;
    chk("rd_wr_req", e, {o_rd_req, o_wr_req});
    idle(1);
    {i_rd_n, i_wr_n, i_data_strobe_n} = 3'h7;
    idle(1);
  endtask

  // expected {out, oe} of pin n under function code c
  function automatic logic [1:0] pin_exp(input int n, input logic [1:0] c);
    logic o;
    logic e;
    o = i_gpio_out[n];
    e = i_gpio_oe[n];
    if (c == FN_ALARM && (n == 0 || n == 1 || n == 4)) begin
      o = (n == 0) ? i_alarm_one : (n == 1) ? i_alarm_two : i_alarm_five;
      e = 1'h1;
    end else if (c == FN_REF && n == 1) begin
      o = i_ref_8khz_out;
      e = 1'h1;
    end else if ((c == FN_REF && n == 3) || (c == FN_SPECIAL && (n == 5 || n == 7))) begin
      e = 1'h0;
    end
    return {o, e};
  endfunction

  initial begin
    idle(3);
    chk("core_rst_held", 1'h0, o_core_resetn);
    i_resetn = 1'h1;
    idle(4);
    chk("core_rst_done", 1'h1, o_core_resetn);
    for (int k = 0; k < 8; k++) begin
      i_strap = sgp_strap_t'(k[2:0]);
      idle(10);
      chk("strap", k[15:0], o_strap);
    end
    // a strap change during a bus cycle must wait for idle
    i_bus_active = 1'h1;
    i_strap = 3'h2;
    idle(10);
    chk("strap_frozen", 3'h7, o_strap);
    i_bus_active = 1'h0;
    idle(10);
    chk("strap_idle", 3'h2, o_strap);
    // mode 0: wide bus, read/write strobes; mode 1: narrow bus, data strobe
    for (int m = 0; m < 2; m++) begin
      i_strap = m ? 3'h4 : 3'h2;
      ex = m ? 8'h09 : 8'h91;
      idle(10);
      for (int s = 0; s < 2; s++) begin
        i_byte_swap_sel = s[0];
        i_bus_active = 1'h1;
        {i_rd_n, i_data_strobe_n} = m ? 2'h2 : 2'h1;
        idle(2);
        if (m) chk("rd_narrow", s ? 16'h12 : 16'hc4, o_bus_rdata[7:0]);
        else chk("rd_wide", s ? 16'hc412 : 16'h12c4, o_bus_rdata);
        chk("lane_oe", m ? 16'h1 : 16'h3, o_bus_lane_oe);
        {i_rd_n, i_data_strobe_n} = 2'h3;
        i_bus_active = 1'h0;
        idle(1);
      end
      for (int i = 0; i < 4; i++) strobe(stm[i], ex[6-2*i +: 2]);
    end
    for (int p = 0; p < 2; p++) begin
      i_gpio_out = p ? 8'h5a : 8'ha5;
      i_gpio_oe = ~i_gpio_out;
      i_alarm_one = ~i_gpio_out[0];
      i_alarm_five = ~i_gpio_out[4];
      for (int n = 0; n < 8; n++) begin
        for (int c = 0; c < 4; c++) begin
          i_pin_func = 16'(c) << (2 * n);
          #1;
          chk("pin", pin_exp(n, c[1:0]), {o_pin_out[n], o_pin_oe[n]});
          idle(1);
        end
      end
    end
    i_pin_func = '0;
    // a data-strobe read keeps the low lane enabled while floating is tried
    i_data_strobe_n = 1'h0;
    idle(1);
    for (int k = 0; k < 4; k++) begin
      {i_float_outputs_n, i_scan_port_reset_n, i_test_n} = {k[1:0], k[0]};
      #1;
      chk("float_all", k == 0, o_float_all);
      chk("float_oe", (k == 0) ? 8'h00 : i_gpio_oe, o_pin_oe);
      chk("lane_float", (k == 0) ? 16'h0 : 16'h1, o_bus_lane_oe);
      chk("scan_test", !k[0], o_scan_test_mode);
      idle(1);
    end
    i_data_strobe_n = 1'h1;
    // pins four, six and eight take their dedicated inputs
    i_pin_func = 16'hcc80;
    en = 1'h1;
    repeat (3) begin
      @(m_err);
      idle(10);
      chk("err_insert", m_err, o_error_insert_in);
      chk("perf_update", m_pmu, o_perf_monitor_update_in);
    end
    repeat (2) begin
      @(m_ref);
      idle(10);
      chk("ref_in", m_ref, o_ref_8khz_in);
    end
    i_pin_func = '0;
    @(posedge m_err);
    idle(10);
    chk("err_unselected", 1'h0, o_error_insert_in);
    chk("gpio_in_six", 1'h1, o_gpio_in[5]);
    i_resetn = 1'h0;
    #1;
    chk("core_rst_async", 1'h0, o_core_resetn);
    chk("strap_rst", STRAP_RST, o_strap);
    idle(2);
    i_resetn = 1'h1;
    idle(10);
    chk("strap_relatch", 3'h4, o_strap);
    finish_test();
  end
endmodule
`default_nettype wire
